// ### logic/baud_tick_gen.sv
`timescale 1ns/1ps
module baud_tick_gen (
	input wire logic clock, // system clock
	input wire logic arst_n, // async reset
	input wire logic enable, // run the divider
	input wire logic [mstp_cfg_pkg::DIV_W-1:0] divisor, // cycles per bit
	output logic tick // one-cycle bit-rate pulse
);
	import mstp_cfg_pkg::*;

	logic [DIV_W-1:0] count;

	// ------------------------------------------------------------
	// divider; a changed divisor takes effect at once, in the current count
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			count <= '0;
			tick <= 1'b0;
		end else if (!enable) begin
			count <= '0;
			tick <= 1'b0;
		end else if (count >= divisor - DIV_W'(1)) begin
			count <= '0;
			tick <= 1'b1;
		end else begin
			count <= count + DIV_W'(1);
			tick <= 1'b0;
		end
	end

endmodule : baud_tick_gen

// ### logic/loss_timer.sv
`timescale 1ns/1ps
module loss_timer #(
	parameter int unsigned UNIT_CYCLES = mstp_cfg_pkg::LOSS_UNIT_CYCLES // cycles per timeout unit
) (
	input wire logic clock, // system clock
	input wire logic arst_n, // async reset
	input wire logic enable, // supervision active
	input wire logic restart, // valid exchange seen
	input wire logic [15:0] timeout, // limit in units
	output logic expired // silence reached the limit
);
	import mstp_cfg_pkg::*;

	logic [31:0] prescale;
	logic [15:0] units;

	// ------------------------------------------------------------
	// unit prescaler and unit count, both cleared by restart
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			prescale <= '0;
			units <= '0;
		end else if (!enable || restart) begin
			prescale <= '0;
			units <= '0;
		end else if (prescale >= 32'(UNIT_CYCLES - 1)) begin
			prescale <= '0;
			if (units != 16'hffff) begin
				units <= units + 16'h0001; // saturates
			end
		end else begin
			prescale <= prescale + 32'h0000_0001;
		end
	end

	// a zero limit would trip at once; treat it as expired immediately by design
	assign expired = enable && !restart && (units >= timeout);

endmodule : loss_timer

// ### logic/mstp_cfg_pkg.sv
package mstp_cfg_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned LOSS_UNIT_MS = 100;
	localparam int unsigned LOSS_UNIT_CYCLES = (CLK_HZ / 1000) * LOSS_UNIT_MS;

	// ------------------------------------------------------------
	// parameter numbers on the operator access port
	// ------------------------------------------------------------
	localparam logic [7:0] PNUM_PROTOCOL = 8'h01;
	localparam logic [7:0] PNUM_NODE = 8'h02;
	localparam logic [7:0] PNUM_BAUD = 8'h03;
	localparam logic [7:0] PNUM_LOSS_REACT = 8'h05;
	localparam logic [7:0] PNUM_LOSS_TIMEOUT = 8'h06;
	localparam logic [7:0] PNUM_INST_LOW = 8'h08;
	localparam logic [7:0] PNUM_INST_HIGH = 8'h09;
	localparam logic [7:0] PNUM_PRESET = 8'h0a;
	localparam logic [7:0] PNUM_STATUS = 8'h80;

	// ------------------------------------------------------------
	// reset values and upper limits of the settings
	// ------------------------------------------------------------
	localparam logic [15:0] RST_PROTOCOL = 16'h0003;
	localparam logic [15:0] RST_NODE = 16'h0001;
	localparam logic [15:0] RST_BAUD = 16'h0003;
	localparam logic [15:0] RST_LOSS_REACT = 16'h0001;
	localparam logic [15:0] RST_LOSS_TIMEOUT = 16'h0014;
	localparam logic [15:0] RST_INST_LOW = 16'h0001;
	localparam logic [15:0] RST_INST_HIGH = 16'h0000;
	localparam logic [15:0] RST_PRESET = 16'h0000;
	localparam logic [15:0] MAX_PROTOCOL = 16'h0003;
	localparam logic [15:0] MAX_NODE = 16'h007f;
	localparam logic [15:0] MAX_BAUD = 16'h0008;
	localparam logic [15:0] MAX_LOSS_REACT = 16'h0004;
	localparam logic [15:0] MAX_INST_HIGH = 16'h003f;

	// ------------------------------------------------------------
	// codes
	// ------------------------------------------------------------
	localparam logic [15:0] PROTO_MODBUS = 16'h0000;
	localparam logic [15:0] PROTO_N2 = 16'h0001;
	localparam logic [15:0] PROTO_P1 = 16'h0002;
	localparam logic [15:0] PROTO_BACNET = 16'h0003;
	localparam logic [15:0] BAUD_MIN_BACNET = 16'h0003;
	localparam logic [15:0] LOSS_IGNORE = 16'h0000;
	localparam logic [15:0] LOSS_ALARM = 16'h0001;
	localparam logic [15:0] LOSS_FAULT = 16'h0002;
	localparam logic [15:0] LOSS_FAULT_OPEN = 16'h0003;
	localparam logic [15:0] LOSS_PRESET = 16'h0004;
	localparam logic [15:0] ALARM_CODE_COMM_LOSS = 16'h000e;
	localparam int unsigned STATUS_LOSS = 0;
	localparam int unsigned STATUS_BAUD_ERR = 1;
	localparam int unsigned STATUS_ACTIVE = 2;
	localparam int unsigned STATUS_BUSY = 3;

	// bit rates selected by baud codes 0 to 8
	localparam int unsigned BAUD_RATE [9] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 76800, 115200};
	localparam int unsigned DIV_W = 17;

	// clock cycles per bit, rounded to nearest
	function automatic logic [DIV_W-1:0] baud_divisor(input logic [15:0] code);
		int unsigned rate;
		rate = BAUD_RATE[3];
		if (code <= MAX_BAUD) begin
			rate = BAUD_RATE[code[3:0]];
		end
		return DIV_W'((CLK_HZ + rate / 2) / rate);
	endfunction : baud_divisor

endpackage : mstp_cfg_pkg

// ### logic/mstp_port_config_supervisor.sv
// Overview of operation
// RQ1: protocol code 0..3, resets to BACnet 3
// RQ2: node address 0..127, resets to 1
// RQ3: integrator keeps node addresses unique per segment
// RQ4: at most 127 devices per segment
// RQ5: baud code 0..8 picks rate, default 9600
// RQ6: BACnet with baud code below 3 flags error
// RQ7: silence past timeout declares communication loss
// RQ8: loss reaction 0..4, default 1 alarm
// RQ9: reaction 2 sends external fault to drive
// RQ10: reaction 3 also opens bypass contactor
// RQ11: reaction 4 shows alarm, runs preset speed
// RQ12: instance id from low and high words
// RQ13: controller initiates, device executes then responds
// RQ14: answer at once, slow commands await token
// RQ15: operator power-cycles after changing settings
// RQ16: loss timer restarts per exchange, idle at 0
`timescale 1ns/1ps
module mstp_port_config_supervisor #(
	parameter int unsigned LOSS_UNIT_CYCLES = mstp_cfg_pkg::LOSS_UNIT_CYCLES // cycles per 100 ms unit
) (
	input wire logic clock, // 50 MHz system clock
	input wire logic arst_n, // async reset, active low
	input wire logic param_wr, // operator write strobe
	input wire logic [7:0] param_sel, // parameter number
	input wire logic [15:0] param_wdata, // value to write
	output logic [15:0] param_rdata, // selected parameter value
	output logic param_reject, // write refused, out of range
	input wire logic req_valid, // request addressed to us
	input wire logic req_slow, // request needs extra processing
	input wire logic proc_done, // local function finished
	input wire logic token_held, // we own the token now
	output logic resp_send, // send the response now
	output logic busy, // request in progress
	output logic [1:0] protocol_code, // active protocol
	output logic [6:0] station_address, // physical station address
	output logic [21:0] instance_id, // device object instance
	output logic bacnet_active, // BACnet selected and legal
	output logic illegal_baud_error, // illegal baud for BACnet
	output logic bit_tick, // bit-rate enable pulse
	output logic comm_loss, // communication loss latched
	output logic comm_loss_alarm, // alarm to operator
	output logic external_fault_indication, // fault sent to drive
	output logic bypass_contactor_open, // open bypass contactor
	output logic preset_run, // run at preset speed
	output logic [15:0] preset_speed, // preset speed setting
	output logic [15:0] display_code // alarm code for display
);
	import mstp_cfg_pkg::*;

	typedef enum {st_idle, st_process, st_wait_token, st_respond} xfer_state_e;

	// ------------------------------------------------------------
	// settings
	// ------------------------------------------------------------
	logic [15:0] protocol_select;
	logic [15:0] node_address;
	logic [15:0] baud_code;
	logic [15:0] loss_reaction_select;
	logic [15:0] loss_timeout_setting;
	logic [15:0] instance_id_low;
	logic [15:0] instance_id_high;
	logic [15:0] preset_speed_setting;

	logic wr_in_range;
	logic next_reject;
	logic [15:0] next_rdata;
	logic [15:0] status_word;

	xfer_state_e state;
	xfer_state_e next_state;
	logic slow_pending;

	logic timer_enable;
	logic timer_expired;
	logic [DIV_W-1:0] divisor;

	// ------------------------------------------------------------
	// write range check, one limit per bounded parameter
	// ------------------------------------------------------------
	always_comb begin
		wr_in_range = 1'b1;
		if (param_sel == PNUM_PROTOCOL) begin
			wr_in_range = (param_wdata <= MAX_PROTOCOL); // see RQ1
		end else if (param_sel == PNUM_NODE) begin
			wr_in_range = (param_wdata <= MAX_NODE); // see RQ2
		end else if (param_sel == PNUM_BAUD) begin
			wr_in_range = (param_wdata <= MAX_BAUD); // see RQ5
		end else if (param_sel == PNUM_LOSS_REACT) begin
			wr_in_range = (param_wdata <= MAX_LOSS_REACT); // see RQ8
		end else if (param_sel == PNUM_INST_HIGH) begin
			wr_in_range = (param_wdata <= MAX_INST_HIGH); // see RQ12
		end else if (param_sel == PNUM_LOSS_TIMEOUT || param_sel == PNUM_INST_LOW
			|| param_sel == PNUM_PRESET) begin
			wr_in_range = 1'b1;
		end else begin
			wr_in_range = 1'b0; // unknown number or read-only status
		end
	end

	assign next_reject = param_wr && !wr_in_range;

	// ------------------------------------------------------------
	// setting registers; a refused write leaves the old value
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			protocol_select <= RST_PROTOCOL; // see RQ1
			node_address <= RST_NODE; // see RQ2
			baud_code <= RST_BAUD; // see RQ5
			loss_reaction_select <= RST_LOSS_REACT; // see RQ8
			loss_timeout_setting <= RST_LOSS_TIMEOUT;
			instance_id_low <= RST_INST_LOW; // see RQ12
			instance_id_high <= RST_INST_HIGH; // see RQ12
			preset_speed_setting <= RST_PRESET;
		end else if (param_wr && wr_in_range) begin
			if (param_sel == PNUM_PROTOCOL) begin
				protocol_select <= param_wdata;
			end else if (param_sel == PNUM_NODE) begin
				node_address <= param_wdata;
			end else if (param_sel == PNUM_BAUD) begin
				baud_code <= param_wdata;
			end else if (param_sel == PNUM_LOSS_REACT) begin
				loss_reaction_select <= param_wdata;
			end else if (param_sel == PNUM_LOSS_TIMEOUT) begin
				loss_timeout_setting <= param_wdata;
			end else if (param_sel == PNUM_INST_LOW) begin
				instance_id_low <= param_wdata;
			end else if (param_sel == PNUM_INST_HIGH) begin
				instance_id_high <= param_wdata;
			end else if (param_sel == PNUM_PRESET) begin
				preset_speed_setting <= param_wdata;
			end
		end
	end

	// refusal pulse, one cycle after the strobe
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			param_reject <= 1'b0;
		end else begin
			param_reject <= next_reject;
		end
	end

	// ------------------------------------------------------------
	// readback, registered so the port sees a clean value
	// ------------------------------------------------------------
	assign status_word = {12'h000, busy, bacnet_active, illegal_baud_error, comm_loss};

	always_comb begin
		next_rdata = 16'h0000;
		if (param_sel == PNUM_PROTOCOL) begin
			next_rdata = protocol_select;
		end else if (param_sel == PNUM_NODE) begin
			next_rdata = node_address;
		end else if (param_sel == PNUM_BAUD) begin
			next_rdata = baud_code;
		end else if (param_sel == PNUM_LOSS_REACT) begin
			next_rdata = loss_reaction_select;
		end else if (param_sel == PNUM_LOSS_TIMEOUT) begin
			next_rdata = loss_timeout_setting;
		end else if (param_sel == PNUM_INST_LOW) begin
			next_rdata = instance_id_low;
		end else if (param_sel == PNUM_INST_HIGH) begin
			next_rdata = instance_id_high;
		end else if (param_sel == PNUM_PRESET) begin
			next_rdata = preset_speed_setting;
		end else if (param_sel == PNUM_STATUS) begin
			next_rdata = status_word;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			param_rdata <= 16'h0000;
		end else begin
			param_rdata <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// derived configuration
	// ------------------------------------------------------------
	// the error is a level: it clears as soon as either setting is fixed
	assign illegal_baud_error = (protocol_select == PROTO_BACNET)
		&& (baud_code < BAUD_MIN_BACNET); // see RQ6
	// an illegal setting keeps the port silent rather than half-working
	assign bacnet_active = (protocol_select == PROTO_BACNET) && !illegal_baud_error; // see RQ6
	assign protocol_code = protocol_select[1:0]; // see RQ1
	assign station_address = node_address[6:0]; // see RQ2
	assign instance_id = {instance_id_high[5:0], instance_id_low}; // see RQ12
	assign preset_speed = preset_speed_setting;
	assign divisor = baud_divisor(baud_code); // see RQ5

	baud_tick_gen u_baud (
		.clock(clock),
		.arst_n(arst_n),
		.enable(bacnet_active),
		.divisor(divisor),
		.tick(bit_tick)
	);

	// ------------------------------------------------------------
	// request and response sequencing
	// ------------------------------------------------------------
	// only the controller starts an exchange; requests arriving while busy are dropped
	always_comb begin
		next_state = state;
		case (state)
			st_idle: begin
				if (req_valid && bacnet_active) begin
					next_state = st_process; // see RQ13
				end
			end
			st_process: begin
				if (proc_done) begin
					next_state = slow_pending ? st_wait_token : st_respond; // see RQ14
				end
			end
			st_wait_token: begin
				if (token_held) begin
					next_state = st_respond; // see RQ14
				end
			end
			st_respond: begin
				next_state = st_idle;
			end
			default: begin
				next_state = st_idle;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= st_idle;
		end else begin
			state <= next_state;
		end
	end

	// remember whether the request asked for deferral
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			slow_pending <= 1'b0;
		end else if (state == st_idle && req_valid && bacnet_active) begin
			slow_pending <= req_slow;
		end
	end

	assign resp_send = (state == st_respond); // see RQ13
	assign busy = (state != st_idle);

	// ------------------------------------------------------------
	// communication loss supervision
	// ------------------------------------------------------------
	assign timer_enable = bacnet_active && (loss_reaction_select != LOSS_IGNORE); // see RQ16

	loss_timer #(
		.UNIT_CYCLES(LOSS_UNIT_CYCLES)
	) u_loss (
		.clock(clock),
		.arst_n(arst_n),
		.enable(timer_enable),
		.restart(req_valid), // see RQ16
		.timeout(loss_timeout_setting),
		.expired(timer_expired)
	);

	// loss is sticky until the next exchange or supervision off; a request masks expiry, so that clear wins
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			comm_loss <= 1'b0;
		end else if (timer_expired) begin
			comm_loss <= 1'b1; // see RQ7
		end else if (req_valid || !timer_enable) begin
			comm_loss <= 1'b0; // see RQ8
		end
	end

	// ------------------------------------------------------------
	// loss reactions, registered so outputs never glitch
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			comm_loss_alarm <= 1'b0;
			external_fault_indication <= 1'b0;
			bypass_contactor_open <= 1'b0;
			preset_run <= 1'b0;
			display_code <= 16'h0000;
		end else begin
			comm_loss_alarm <= comm_loss && (loss_reaction_select == LOSS_ALARM
				|| loss_reaction_select == LOSS_PRESET); // see RQ8
			external_fault_indication <= comm_loss && (loss_reaction_select == LOSS_FAULT
				|| loss_reaction_select == LOSS_FAULT_OPEN); // see RQ9
			bypass_contactor_open <= comm_loss && (loss_reaction_select == LOSS_FAULT_OPEN); // see RQ10
			preset_run <= comm_loss && (loss_reaction_select == LOSS_PRESET); // see RQ11
			display_code <= (comm_loss && loss_reaction_select == LOSS_PRESET)
				? ALARM_CODE_COMM_LOSS : 16'h0000; // see RQ11
		end
	end

endmodule : mstp_port_config_supervisor

// ### sim/mstp_port_config_supervisor_props.sv
`timescale 1ns/1ps
module mstp_port_config_supervisor_props
	import mstp_cfg_pkg::*;
(
	input wire logic clock, // system clock
	input wire logic arst_n, // async reset
	input wire logic param_wr, // write strobe
	input wire logic [7:0] param_sel, // parameter number
	input wire logic [15:0] param_wdata, // write value
	input wire logic param_reject, // refused write
	input wire logic req_valid, // request in
	input wire logic proc_done, // local work done
	input wire logic token_held, // token owned
	input wire logic resp_send, // response out
	input wire logic busy, // request open
	input wire logic [1:0] protocol_code, // active protocol
	input wire logic bacnet_active, // legal BACnet
	input wire logic illegal_baud_error, // baud error
	input wire logic comm_loss, // loss latched
	input wire logic comm_loss_alarm, // operator alarm
	input wire logic external_fault_indication, // fault to drive
	input wire logic bypass_contactor_open, // contactor open
	input wire logic preset_run, // preset speed run
	input wire logic [15:0] display_code // display code
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	logic [15:0] react;
	logic [15:0] baud;

	// ------------------------------------------------------------
	// setting shadows
	// ------------------------------------------------------------
	// only accepted writes move them, so a refused write cannot skew the checks
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			react <= RST_LOSS_REACT;
			baud <= RST_BAUD;
		end else if (param_wr && param_sel == PNUM_LOSS_REACT && param_wdata <= MAX_LOSS_REACT) begin
			react <= param_wdata;
		end else if (param_wr && param_sel == PNUM_BAUD && param_wdata <= MAX_BAUD) begin
			baud <= param_wdata;
		end
	end

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	sequence s_big(logic [7:0] sel, logic [15:0] lim); param_wr && param_sel == sel && param_wdata > lim; endsequence
	sequence s_loss(logic [15:0] code); comm_loss && react == code; endsequence
	property p_proto; s_big(PNUM_PROTOCOL, MAX_PROTOCOL) |=> param_reject; endproperty
	property p_node; s_big(PNUM_NODE, MAX_NODE) |=> param_reject; endproperty
	property p_baud; s_big(PNUM_BAUD, MAX_BAUD) |=> param_reject; endproperty
	property p_baud_err; illegal_baud_error == (protocol_code == 2'h3 && baud < BAUD_MIN_BACNET)
		&& bacnet_active == (protocol_code == 2'h3 && !illegal_baud_error); endproperty
	property p_accept; !busy && req_valid && bacnet_active |=> busy [*2]; endproperty
	property p_resp_cause; resp_send |-> $past(proc_done) || $past(token_held); endproperty
	property p_resp_close; resp_send |-> busy ##1 !busy && !resp_send; endproperty
	property p_ignore; react == LOSS_IGNORE |=> !comm_loss; endproperty
	property p_alarm; s_loss(LOSS_ALARM) |=> comm_loss_alarm && !external_fault_indication && !preset_run; endproperty
	property p_fault; s_loss(LOSS_FAULT) |=> external_fault_indication && !bypass_contactor_open; endproperty
	property p_open; s_loss(LOSS_FAULT_OPEN) |=> external_fault_indication && bypass_contactor_open; endproperty
	property p_preset; s_loss(LOSS_PRESET) |=> preset_run && display_code == ALARM_CODE_COMM_LOSS; endproperty
	a_proto: assert property (p_proto) else $error("protocol overrange write kept");
	a_node: assert property (p_node) else $error("node overrange write kept");
	a_baud: assert property (p_baud) else $error("baud overrange write kept");
	a_baud_err: assert property (p_baud_err) else $error("baud error flag wrong");
	a_accept: assert property (p_accept) else $error("request not taken");
	a_resp_cause: assert property (p_resp_cause) else $error("response without cause");
	a_resp_close: assert property (p_resp_close) else $error("response did not close");
	a_ignore: assert property (p_ignore) else $error("loss kept while ignored");
	a_alarm: assert property (p_alarm) else $error("alarm reaction wrong");
	a_fault: assert property (p_fault) else $error("fault reaction wrong");
	a_open: assert property (p_open) else $error("contactor reaction wrong");
	a_preset: assert property (p_preset) else $error("preset reaction wrong");
endmodule : mstp_port_config_supervisor_props

bind mstp_port_config_supervisor mstp_port_config_supervisor_props u_props (.clock, .arst_n, .param_wr,
	.param_sel, .param_wdata, .param_reject, .req_valid, .proc_done, .token_held, .resp_send, .busy,
	.protocol_code, .bacnet_active, .illegal_baud_error, .comm_loss, .comm_loss_alarm,
	.external_fault_indication, .bypass_contactor_open, .preset_run, .display_code);

// ### sim/net_controller_model.sv
`timescale 1ns/1ps
module net_controller_model (
	input wire logic clock, // system clock
	input wire logic arst_n, // async reset
	input wire logic go, // bench asks for one request
	input wire logic slow, // kind of that request
	input wire logic [3:0] token_gap, // cycles between token visits
	output logic req_valid, // request to the device
	output logic req_slow, // request needs deferral
	output logic token_held // token lent to the device
);
	logic [3:0] cnt;

	// the controller alone opens exchanges, and only once out of reset
	// one device on the segment, so its address is never shared
	always_ff @(negedge clock or negedge arst_n) begin
		if (!arst_n) begin
			req_valid <= 1'b0;
			req_slow <= 1'b0;
			cnt <= 4'h0;
			token_held <= 1'b0;
		end else begin
			req_valid <= go;
			// an unqualified kind line toggles rather than keep a stale value
			req_slow <= go ? slow : ~req_slow;
			cnt <= (cnt >= token_gap) ? 4'h0 : cnt + 4'h1;
			token_held <= (cnt >= token_gap);
		end
	end
endmodule : net_controller_model

// ### sim/tb_mstp_port_config_supervisor.sv
`timescale 1ns/1ps
module tb_mstp_port_config_supervisor;
	import mstp_cfg_pkg::*;
	localparam int unsigned UNIT = 4;
	logic clock, arst_n, param_wr, proc_done, go, slow, param_reject, req_valid, req_slow, token_held;
	logic resp_send, busy, bacnet_active, illegal_baud_error, bit_tick, comm_loss, comm_loss_alarm;
	logic external_fault_indication, bypass_contactor_open, preset_run;
	logic [7:0] param_sel;
	logic [15:0] param_wdata, param_rdata, preset_speed, display_code;
	logic [1:0] protocol_code;
	logic [6:0] station_address;
	logic [21:0] instance_id;
	logic [3:0] token_gap;
	logic [15:0] sh [256];
	int n_mismatch, n_tests;
	int unsigned rates [9] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 76800, 115200};
	logic [7:0] sels [10] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h80, 8'h04};
	logic [3:0] rx [5] = '{4'b0000, 4'b1000, 4'b0100, 4'b0110, 4'b1001};

	mstp_port_config_supervisor #(.LOSS_UNIT_CYCLES(UNIT)) u_dut (.clock, .arst_n, .param_wr, .param_sel,
		.param_wdata, .param_rdata, .param_reject, .req_valid, .req_slow, .proc_done, .token_held, .resp_send,
		.busy, .protocol_code, .station_address, .instance_id, .bacnet_active, .illegal_baud_error, .bit_tick,
		.comm_loss, .comm_loss_alarm, .external_fault_indication, .bypass_contactor_open, .preset_run,
		.preset_speed, .display_code);
	net_controller_model u_ctrl (.clock, .arst_n, .go, .slow, .token_gap, .req_valid, .req_slow, .token_held);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop

	// open settings have no ceiling, unknown numbers never take a value
	function automatic logic [15:0] lim(input logic [7:0] s);
		case (s)
			PNUM_PROTOCOL: return MAX_PROTOCOL;
			PNUM_NODE: return MAX_NODE;
			PNUM_BAUD: return MAX_BAUD;
			PNUM_LOSS_REACT: return MAX_LOSS_REACT;
			PNUM_INST_HIGH: return MAX_INST_HIGH;
			default: return 16'hffff;
		endcase
	endfunction : lim

	task automatic outs();
		check(protocol_code, sh[1][1:0]);
		check(station_address, sh[2][6:0]);
		check(instance_id, {sh[9][5:0], sh[8]});
		check(illegal_baud_error, sh[1] == 16'h3 && sh[3] < 16'h3);
		check(bacnet_active, sh[1] == 16'h3 && sh[3] >= 16'h3);
		check(preset_speed, sh[10]);
	endtask : outs

	task automatic rd(input logic [7:0] s);
		param_sel <= s;
		@(negedge clock);
		if (s != PNUM_STATUS) check(param_rdata, sh[s]);
		else check(param_rdata[2:1], {sh[1] == 16'h3 && sh[3] >= 16'h3, sh[1] == 16'h3 && sh[3] < 16'h3});
	endtask : rd

	task automatic wr(input logic [7:0] s, input logic [15:0] d);
		logic ok;
		ok = s != PNUM_STATUS && s != 8'h04 && d <= lim(s);
		@(negedge clock);
		param_sel <= s;
		param_wdata <= d;
		param_wr <= 1'b1;
		@(negedge clock);
		param_wr <= 1'b0;
		check(param_reject, !ok);
		if (ok) sh[s] = d;
		rd(s);
		outs();
	endtask : wr

	// a second request while busy must be ignored and not lengthen the exchange
	task automatic xfer(input logic sl, input int dly);
		int k;
		slow <= sl;
		go <= 1'b1;
		@(negedge clock);
		go <= 1'b0;
		@(negedge clock);
		check(busy, 1);
		go <= 1'b1;
		@(negedge clock);
		go <= 1'b0;
		repeat (dly) @(negedge clock);
		proc_done <= 1'b1;
		@(negedge clock);
		proc_done <= 1'b0;
		k = 0;
		if (!sl) check(resp_send, 1);
		while (resp_send !== 1'b1 && k < 40) begin
			@(negedge clock);
			k++;
		end
		if (sl) check(token_held, 1);
		@(negedge clock);
		check(busy, 0);
	endtask : xfer

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int k;
		logic [7:0] s;
		logic [15:0] d;
		arst_n = 1'b0;
		param_wr = 1'b0;
		param_sel = 8'h00;
		param_wdata = 16'h0000;
		proc_done = 1'b0;
		go = 1'b0;
		slow = 1'b0;
		token_gap = 4'h3;
		void'($urandom(40));
		foreach (sh[i]) sh[i] = 16'h0000;
		sh[1] = RST_PROTOCOL;
		sh[2] = RST_NODE;
		sh[3] = RST_BAUD;
		sh[5] = RST_LOSS_REACT;
		sh[6] = RST_LOSS_TIMEOUT;
		sh[8] = RST_INST_LOW;
		sh[9] = RST_INST_HIGH;
		sh[10] = RST_PRESET;
		repeat (20) @(negedge clock);
		outs();
		arst_n <= 1'b1;
		for (int i = 0; i < 8; i++) rd(sels[i]);
		// boundaries and random values, refused ones among them
		for (int i = 0; i < 80; i++) begin
			s = sels[$urandom % 10];
			case ($urandom % 3)
				0: d = lim(s);
				1: d = lim(s) + 16'h1;
				default: d = 16'($urandom);
			endcase
			wr(s, d);
		end
		wr(PNUM_PROTOCOL, PROTO_BACNET);
		wr(PNUM_LOSS_TIMEOUT, 16'h2);
		wr(PNUM_LOSS_REACT, LOSS_IGNORE);
		for (int c = 3; c < 9; c++) begin
			wr(PNUM_BAUD, 16'(c));
			for (int j = 0; j < 3; j++) begin
				k = 0;
				do begin
					@(negedge clock);
					k++;
				end while (bit_tick !== 1'b1 && k < 6000);
			end
			check(k, (50_000_000 + rates[c] / 2) / rates[c]);
		end
		for (int i = 0; i < 8; i++) begin
			token_gap <= 4'($urandom);
			xfer(1'($urandom % 2), $urandom % 6);
		end
		// loss reactions last: the opening request is never finished
		for (int r = 0; r < 5; r++) begin
			wr(PNUM_LOSS_REACT, 16'(r));
			go <= 1'b1;
			@(negedge clock);
			go <= 1'b0;
			k = 0;
			do begin
				@(negedge clock);
				k++;
			end while (comm_loss !== 1'b1 && k < 30);
			if (r == 0) check(comm_loss, 0);
			else check(k >= 2 * UNIT - 1 && k <= 2 * UNIT + 3, 1);
			@(negedge clock);
			check({comm_loss_alarm, external_fault_indication, bypass_contactor_open, preset_run}, rx[r]);
			check(display_code, r == 4 ? ALARM_CODE_COMM_LOSS : 16'h0000);
		end
		report_and_stop();
	end

	// cuts a hang short; the full run needs about 35,000 cycles, 0.7 ms
	initial begin
		#1_500_000;
		n_mismatch++;
		report_and_stop();
	end
endmodule : tb_mstp_port_config_supervisor
